// ===== inc/hpio_pkg.sv
/*
  Shared constants for the programmable I/O port block: register
  offsets, field codes, masks, reset values and mode encodings.
  Assumes a host bus with a 5-bit address and an 8-bit data path.
*/
package hpio_pkg;
  localparam int WIDE_W = 8;
  localparam int NARROW_W = 3;
  localparam int ADDR_W = 5;
  localparam int DATA_W = 8;
  localparam int IMC_GROUP = 4;

  // Address form for port registers is {1'b0, port, field}
  localparam logic [1:0] PORT_B = 2'h0;
  localparam logic [1:0] PORT_C = 2'h1;
  localparam logic [1:0] PORT_D = 2'h2;
  localparam logic [1:0] FLD_DIN = 2'h0;
  localparam logic [1:0] FLD_DOUT = 2'h1;
  localparam logic [1:0] FLD_DIR = 2'h2;
  localparam logic [1:0] FLD_DRV = 2'h3;
  localparam logic [ADDR_W-1:0] OFF_IMC_B = 5'h0c;
  localparam logic [ADDR_W-1:0] OFF_IMC_C = 5'h0d;
  localparam logic [ADDR_W-1:0] OFF_CELL_AB = 5'h0e;
  localparam logic [ADDR_W-1:0] OFF_CELL_BC = 5'h0f;

  localparam logic [DATA_W-1:0] REG_RESET = 8'h00;
  localparam logic [DATA_W-1:0] FULL_MASK = 8'hff;
  localparam logic [DATA_W-1:0] D_ACTIVE_MASK = 8'h07;
  localparam logic [WIDE_W-1:0] B_OD_MASK = 8'hf0;
  localparam logic [WIDE_W-1:0] B_SLEW_MASK = 8'h0f;
  localparam logic [WIDE_W-1:0] C_OD_MASK = 8'hff;
  localparam logic [WIDE_W-1:0] C_SLEW_MASK = 8'h00;
  localparam logic [NARROW_W-1:0] D_OD_MASK = 3'h0;
  localparam logic [NARROW_W-1:0] D_SLEW_MASK = 3'h7;

  typedef enum logic [1:0] {
    IMC_PASS = 2'b00,
    IMC_LATCH = 2'b01,
    IMC_REG = 2'b10
  } hpio_imc_mode_t;

  typedef enum logic [2:0] {
    RB_NONE = 3'b000,
    RB_LEVEL = 3'b001,
    RB_DOUT = 3'b010,
    RB_DIR = 3'b011,
    RB_DRV = 3'b100,
    RB_IMC_B = 3'b101,
    RB_IMC_C = 3'b110,
    RB_CELL = 3'b111
  } hpio_rb_src_t;
endpackage

// ===== hw/hpio_pin_group.sv
/*
  One port's pin logic: input synchroniser, optional input cells,
  output source select, output enable and drive type.
  Assumes register values and logic-array terms on sys_clk.
*/
`timescale 1ns/1ps
module hpio_pin_group
  import hpio_pkg::*;
#(
  parameter int W = 8,
  parameter bit HAS_IMC = 1'b1,
  parameter logic [W-1:0] OD_MASK = '0,
  parameter logic [W-1:0] SLEW_MASK = '0
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic clkEn,
  input wire logic [W-1:0] pinIn,
  input wire logic [W-1:0] dataOut,
  input wire logic [W-1:0] dir,
  input wire logic [W-1:0] drive,
  input wire logic [W-1:0] cellSel,
  input wire logic [W-1:0] cellVal,
  input wire logic [W-1:0] ptDefined,
  input wire logic [W-1:0] enTerm,
  input wire logic [2*W-1:0] imcMode,
  input wire logic [1:0] imcGate,
  output logic [W-1:0] pinOut,
  output logic [W-1:0] pinOe,
  output logic [W-1:0] slewFast,
  output logic [W-1:0] pinLevel,
  output logic [W-1:0] arrayIn
);
  logic [W-1:0] sync1_q, sync2_q, sync3_q, level_q, level_d;
  logic [W-1:0] imc_q, imc_d, imcLoad, imcOut, gateBit, gateRise;
  logic [1:0] gatePrev_q;
  logic [W-1:0] drvVal, oeRaw, odOn, pinOut_d, pinOe_d;

  // Level changes only once the last two stages agree
  assign level_d = (~(sync2_q ^ sync3_q) & sync3_q) |
                   ((sync2_q ^ sync3_q) & level_q);

  // Input cells: one gate term for each group of four pins
  for (genvar i = 0; i < W; i++) begin : g_imc
    hpio_imc_mode_t md;
    assign md = hpio_imc_mode_t'(imcMode[2*i+1 -: 2]);
    assign gateBit[i] = imcGate[i / IMC_GROUP];
    assign gateRise[i] = gateBit[i] & ~gatePrev_q[i / IMC_GROUP];
    assign imcLoad[i] = (md == IMC_LATCH) ? gateBit[i] :
                        (md == IMC_REG) ? gateRise[i] : 1'b1;
    assign imcOut[i] = (md == IMC_PASS ||
                        (md == IMC_LATCH && gateBit[i])) ?
                       level_q[i] : imc_q[i];
  end
  assign imc_d = (imcLoad & level_q) | (~imcLoad & imc_q);
  assign arrayIn = HAS_IMC ? imcOut : level_q;
  assign pinLevel = level_q;

  // Array signal overrides the data-out bit on array-driven pins
  assign drvVal = (cellSel & cellVal) | (~cellSel & dataOut);
  // Undefined term: array output pins on, others follow direction
  assign oeRaw = dir | (ptDefined & enTerm) |
                 (~ptDefined & cellSel);
  // Open drain only ever pulls low; a high releases the pin
  assign odOn = OD_MASK & drive;
  assign pinOut_d = drvVal & ~odOn;
  assign pinOe_d = oeRaw & ~(odOn & drvVal);
  assign slewFast = drive & SLEW_MASK;

  // First stage feeds only the second stage
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      sync1_q <= '0;
      sync2_q <= '0;
      sync3_q <= '0;
      level_q <= '0;
    end else if (clkEn) begin
      sync1_q <= pinIn;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      level_q <= level_d;
    end
  end

  // Input cell state and registered pin drive
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      imc_q <= '0;
      gatePrev_q <= '0;
      pinOut <= '0;
      pinOe <= '0;
    end else if (clkEn) begin
      imc_q <= imc_d;
      gatePrev_q <= imcGate;
      pinOut <= pinOut_d;
      pinOe <= pinOe_d;
    end
  end
endmodule

// ===== hw/hpio_ports.sv
/*
  Three programmable I/O ports with their host-visible configuration
  registers and readback path, plus pin-level assertions.
  Assumes the host bus, logic-array terms and configuration inputs
  are synchronous to sys_clk; pin inputs may be asynchronous.
*/
`timescale 1ns/1ps
// How it works
// - Two eight-pin ports and one three-pin port, every pin separate.
// - Pin driver enable is array enable term OR direction bit.
// - No enable term and no array output: direction alone decides.
// - Output select: data-out, output cell, or chip select on port D.
// - Readback returns one source: level, data-out, direction, drive or cells.
// - First cell group to B only; second to B or C; IN_SYSTEM_PROGRAMMING on C.
// - Host mode: output pins follow data-out, inputs readable as level.
// - B and C inputs pass input cells; D inputs go straight in.
// - B from first or second group, C second group, D chip selects.
// - Array output floats when enable term low and direction zero.
// - Bit n maps to pin n; configuration registers reset to zero.
// - Ordinary bus reads and writes; data-in is read only.
// - Data-in read returns actual pin level, whoever drives it.
// - Data-out writes do not reach pins driven by the array.
// - Direction one means output, zero input; all inputs after reset.
// - B and C input cells act as register, latch or pass-through.
// - Drive bit: open drain on B7-4 and C, fast slew on B3-0 and D.
// - Only the low three direction bits of port D exist.
module hpio_ports
  import hpio_pkg::*;
#(
  parameter logic [WIDE_W-1:0] ISP_PIN_MASK = 8'h0f
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic clkEn,
  input wire logic [ADDR_W-1:0] hostAddr,
  input wire logic [DATA_W-1:0] hostWrData,
  input wire logic hostWrEn,
  input wire logic hostRdEn,
  output logic [DATA_W-1:0] hostRdData,
  input wire logic [WIDE_W-1:0] portBIn,
  output logic [WIDE_W-1:0] portBOut,
  output logic [WIDE_W-1:0] portBOe,
  output logic [WIDE_W-1:0] portBFastSlew,
  input wire logic [WIDE_W-1:0] portCIn,
  output logic [WIDE_W-1:0] portCOut,
  output logic [WIDE_W-1:0] portCOe,
  input wire logic [NARROW_W-1:0] portDIn,
  output logic [NARROW_W-1:0] portDOut,
  output logic [NARROW_W-1:0] portDOe,
  output logic [NARROW_W-1:0] portDFastSlew,
  input wire logic [WIDE_W-1:0] firstCellOut,
  input wire logic [WIDE_W-1:0] secondCellOut,
  input wire logic [NARROW_W-1:0] extSelect,
  input wire logic [WIDE_W-1:0] bCellSel,
  input wire logic [WIDE_W-1:0] bSecondSel,
  input wire logic [WIDE_W-1:0] cCellSel,
  input wire logic [NARROW_W-1:0] dCellSel,
  input wire logic [WIDE_W-1:0] bPtDefined,
  input wire logic [WIDE_W-1:0] cPtDefined,
  input wire logic [NARROW_W-1:0] dPtDefined,
  input wire logic [WIDE_W-1:0] bEnTerm,
  input wire logic [WIDE_W-1:0] cEnTerm,
  input wire logic [NARROW_W-1:0] dEnTerm,
  input wire logic [2*WIDE_W-1:0] bImcMode,
  input wire logic [2*WIDE_W-1:0] cImcMode,
  input wire logic [1:0] bImcGate,
  input wire logic [1:0] cImcGate,
  input wire logic ispEnable,
  input wire logic [WIDE_W-1:0] ispOutVal,
  input wire logic [WIDE_W-1:0] ispOeVal,
  output logic [WIDE_W-1:0] bArrayIn,
  output logic [WIDE_W-1:0] cArrayIn,
  output logic [NARROW_W-1:0] dArrayIn
);
  logic [DATA_W-1:0] outVal_q [3];
  logic [DATA_W-1:0] dirBits_q [3];
  logic [DATA_W-1:0] drvSel_q [3];
  logic [DATA_W-1:0] rdData_q;
  logic [DATA_W-1:0] rdNext;
  logic [DATA_W-1:0] level [3];
  logic [WIDE_W-1:0] bLevel, cLevel;
  logic [NARROW_W-1:0] dLevel;
  logic [1:0] portIdx, fieldIdx;
  logic portHit;
  logic [2:0] wrPort;
  hpio_rb_src_t rbSrc;
  logic [WIDE_W-1:0] bCellVal, cRouted, ispOn;
  logic [WIDE_W-1:0] cSel, cVal, cPtDef, cEn;

  // Port D keeps only its three live bits
  function automatic logic [DATA_W-1:0] portMask(input logic [1:0] p);
    portMask = (p == PORT_D) ? D_ACTIVE_MASK : FULL_MASK;
  endfunction

  // Address to readback source; unmapped reads give zero
  function automatic hpio_rb_src_t srcOf(input logic [ADDR_W-1:0] a);
    if (!a[4] && a[3:2] != 2'h3) begin
      case (a[1:0])
        FLD_DIN: srcOf = RB_LEVEL;
        FLD_DOUT: srcOf = RB_DOUT;
        FLD_DIR: srcOf = RB_DIR;
        default: srcOf = RB_DRV;
      endcase
    end else begin
      case (a)
        OFF_IMC_B: srcOf = RB_IMC_B;
        OFF_IMC_C: srcOf = RB_IMC_C;
        OFF_CELL_AB: srcOf = RB_CELL;
        OFF_CELL_BC: srcOf = RB_CELL;
        default: srcOf = RB_NONE;
      endcase
    end
  endfunction

  // Host address decode
  assign portIdx = hostAddr[3:2];
  assign fieldIdx = hostAddr[1:0];
  assign portHit = !hostAddr[4] && (portIdx != 2'h3);
  assign rbSrc = srcOf(hostAddr);
  // Data-in field has no storage, so writes there fall away
  assign wrPort[0] = hostWrEn && portHit && portIdx == PORT_B;
  assign wrPort[1] = hostWrEn && portHit && portIdx == PORT_C;
  assign wrPort[2] = hostWrEn && portHit && portIdx == PORT_D;

  // Port register file, bit n of each register is pin n
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      for (int p = 0; p < 3; p++) begin
        outVal_q[p] <= REG_RESET;
        dirBits_q[p] <= REG_RESET;
        drvSel_q[p] <= REG_RESET;
      end
    end else if (clkEn) begin
      for (int p = 0; p < 3; p++) begin
        if (wrPort[p]) begin
          case (fieldIdx)
            FLD_DOUT: outVal_q[p] <= hostWrData & portMask(2'(p));
            FLD_DIR: dirBits_q[p] <= hostWrData & portMask(2'(p));
            FLD_DRV: drvSel_q[p] <= hostWrData & portMask(2'(p));
            default: ;
          endcase
        end
      end
    end
  end

  // Pin levels as seen through the synchronisers
  assign level[0] = bLevel;
  assign level[1] = cLevel;
  assign level[2] = {5'h00, dLevel};

  // Readback buffer: exactly one source reaches the data bus
  assign rdNext =
    (rbSrc == RB_LEVEL) ? level[portIdx] :
    (rbSrc == RB_DOUT) ? outVal_q[portIdx] :
    (rbSrc == RB_DIR) ? dirBits_q[portIdx] :
    (rbSrc == RB_DRV) ? drvSel_q[portIdx] :
    (rbSrc == RB_IMC_B) ? bArrayIn :
    (rbSrc == RB_IMC_C) ? cArrayIn :
    (rbSrc == RB_CELL && hostAddr[0]) ? secondCellOut :
    (rbSrc == RB_CELL) ? firstCellOut : 8'h00;

  // Read data held in a register until the next read
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      rdData_q <= REG_RESET;
    end else if (clkEn && hostRdEn) begin
      rdData_q <= rdNext;
    end
  end
  assign hostRdData = rdData_q;

  // Cell routing: a second-group cell lands on B or C, never both
  assign bCellVal = (bSecondSel & secondCellOut) |
                    (~bSecondSel & firstCellOut);
  assign cRouted = cCellSel & ~(bCellSel & bSecondSel);
  // Programming pins on C take the pin while programming is on
  assign ispOn = ispEnable ? ISP_PIN_MASK : 8'h00;
  assign cSel = cRouted | ispOn;
  assign cVal = (ispOn & ispOutVal) | (~ispOn & secondCellOut);
  assign cPtDef = cPtDefined | ispOn;
  assign cEn = (ispOn & ispOeVal) | (~ispOn & cEnTerm);

  // Port B: first or second cell group, input cells present
  hpio_pin_group #(
    .W(WIDE_W),
    .HAS_IMC(1'b1),
    .OD_MASK(B_OD_MASK),
    .SLEW_MASK(B_SLEW_MASK)
  ) u_port_b (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .clkEn(clkEn),
    .pinIn(portBIn),
    .dataOut(outVal_q[0]),
    .dir(dirBits_q[0]),
    .drive(drvSel_q[0]),
    .cellSel(bCellSel),
    .cellVal(bCellVal),
    .ptDefined(bPtDefined),
    .enTerm(bEnTerm),
    .imcMode(bImcMode),
    .imcGate(bImcGate),
    .pinOut(portBOut),
    .pinOe(portBOe),
    .slewFast(portBFastSlew),
    .pinLevel(bLevel),
    .arrayIn(bArrayIn)
  );

  // Port C: second cell group and programming pins, all open drain
  hpio_pin_group #(
    .W(WIDE_W),
    .HAS_IMC(1'b1),
    .OD_MASK(C_OD_MASK),
    .SLEW_MASK(C_SLEW_MASK)
  ) u_port_c (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .clkEn(clkEn),
    .pinIn(portCIn),
    .dataOut(outVal_q[1]),
    .dir(dirBits_q[1]),
    .drive(drvSel_q[1]),
    .cellSel(cSel),
    .cellVal(cVal),
    .ptDefined(cPtDef),
    .enTerm(cEn),
    .imcMode(cImcMode),
    .imcGate(cImcGate),
    .pinOut(portCOut),
    .pinOe(portCOe),
    .slewFast(),
    .pinLevel(cLevel),
    .arrayIn(cArrayIn)
  );

  // Port D: three pins, chip selects, inputs straight to the array
  hpio_pin_group #(
    .W(NARROW_W),
    .HAS_IMC(1'b0),
    .OD_MASK(D_OD_MASK),
    .SLEW_MASK(D_SLEW_MASK)
  ) u_port_d (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .clkEn(clkEn),
    .pinIn(portDIn),
    .dataOut(outVal_q[2][NARROW_W-1:0]),
    .dir(dirBits_q[2][NARROW_W-1:0]),
    .drive(drvSel_q[2][NARROW_W-1:0]),
    .cellSel(dCellSel),
    .cellVal(extSelect),
    .ptDefined(dPtDefined),
    .enTerm(dEnTerm),
    .imcMode(6'h00),
    .imcGate(2'h0),
    .pinOut(portDOut),
    .pinOe(portDOe),
    .slewFast(portDFastSlew),
    .pinLevel(dLevel),
    .arrayIn(dArrayIn)
  );

  // Checks on pin and register behaviour
  sequence sDoutWr;
    clkEn && hostWrEn && hostAddr == {1'b0, PORT_B, FLD_DOUT};
  endsequence

  sequence sDoutRd;
    clkEn && hostRdEn && !hostWrEn &&
      hostAddr == {1'b0, PORT_B, FLD_DOUT};
  endsequence

  chk_dir_drive: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    clkEn && dirBits_q[0][0] |=> portBOe[0])
    else $error("direction bit set but pin not driven");

  chk_float_off: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    clkEn && !dirBits_q[0][0] &&
      !(bPtDefined[0] ? bEnTerm[0] : bCellSel[0]) |=> !portBOe[0])
    else $error("pin driven with no enable source");

  chk_dout_pin: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    clkEn && !bCellSel[0] |=> portBOut[0] == $past(outVal_q[0][0]))
    else $error("host-mode pin does not follow data-out");

  chk_cell_wins: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    clkEn && bCellSel[0] && !bSecondSel[0] |=>
      portBOut[0] == $past(firstCellOut[0]))
    else $error("array pin not taken from first cell group");

  chk_csel_route: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    clkEn && dCellSel[0] |=> portDOut[0] == $past(extSelect[0]))
    else $error("chip select not on port D pin");

  chk_open_drain: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    clkEn && drvSel_q[1][0] |=> !portCOut[0])
    else $error("open-drain pin drove high");

  chk_reset_zero: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    $rose(rstn) |-> outVal_q[0] == 8'h00 && dirBits_q[1] == 8'h00 &&
      drvSel_q[2] == 8'h00)
    else $error("register not zero after reset");

  chk_dout_store: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    sDoutWr ##1 sDoutRd |=> hostRdData == $past(hostWrData, 2))
    else $error("data-out readback differs from write");

  chk_level_read: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    clkEn && hostRdEn && hostAddr == {1'b0, PORT_B, FLD_DIN} |=>
      hostRdData == $past(bLevel))
    else $error("data-in read not the pin level");

  chk_d_upper_zero: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    clkEn && hostRdEn && hostAddr[4:2] == {1'b0, PORT_D} |=>
      hostRdData[7:3] == 5'h00)
    else $error("port D upper bits not zero");
endmodule

// ===== verif/hpio_host_model.sv
/*
  Host processor model driving the port block register bus.
  Assumes the bench calls wr and rd; lines change on falling edges.
*/
`timescale 1ns/1ps
module hpio_host_model
  import hpio_pkg::*;
(
  input wire logic sys_clk,
  output logic [ADDR_W-1:0] hostAddr,
  output logic [DATA_W-1:0] hostWrData,
  output logic hostWrEn,
  output logic hostRdEn,
  input wire logic [DATA_W-1:0] hostRdData
);
  // Idle bus with both strobes low
  initial begin
    hostAddr = '0;
    hostWrData = '0;
    hostWrEn = 1'b0;
    hostRdEn = 1'b0;
  end

  // One-cycle write; released lines show inverted values, not stale ones
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(negedge sys_clk);
    hostAddr = a;
    hostWrData = d;
    hostWrEn = 1'b1;
    @(negedge sys_clk);
    hostWrEn = 1'b0;
    hostAddr = ~a;
    hostWrData = ~d;
  endtask

  // Write then read back on the very next edge; no idle cycle between
  task automatic wr_rd(input logic [ADDR_W-1:0] a,
                       input logic [DATA_W-1:0] wd,
                       output logic [DATA_W-1:0] d);
    @(negedge sys_clk);
    hostAddr = a;
    hostWrData = wd;
    hostWrEn = 1'b1;
    @(negedge sys_clk);
    hostWrEn = 1'b0;
    hostRdEn = 1'b1;
    @(negedge sys_clk);
    hostRdEn = 1'b0;
    hostAddr = ~a;
    hostWrData = ~wd;
    d = hostRdData;
  endtask

  // One-cycle read; data is registered, so taken half a cycle later
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    @(negedge sys_clk);
    hostAddr = a;
    hostRdEn = 1'b1;
    @(negedge sys_clk);
    hostRdEn = 1'b0;
    hostAddr = ~a;
    d = hostRdData;
  endtask
endmodule

// ===== verif/test_hpio_ports.sv
/*
  Self-checking bench for the three-port I/O block.
  Assumes the host model for bus cycles; pins resolve from driver enables.
*/
`timescale 1ns/1ps
module test_hpio_ports
  import hpio_pkg::*;
;
  logic sys_clk, rstn, clkEn, hostWrEn, hostRdEn, ispEnable;
  logic [ADDR_W-1:0] hostAddr;
  logic [DATA_W-1:0] hostWrData, hostRdData, v;
  logic [7:0] portBOut, portBOe, portBFastSlew, portCOut, portCOe;
  logic [7:0] firstCellOut, secondCellOut, bCellSel, bSecondSel, cCellSel;
  logic [7:0] bPtDefined, cPtDefined, bEnTerm, cEnTerm, ispOutVal, ispOeVal;
  logic [7:0] bArrayIn, cArrayIn, extB, extC, pinB, pinC;
  logic [2:0] portDOut, portDOe, portDFastSlew, extSelect, dCellSel;
  logic [2:0] dPtDefined, dEnTerm, dArrayIn, extD, pinD;
  logic [15:0] bImcMode, cImcMode;
  logic [1:0] bImcGate, cImcGate;
  int num_errors, tests_run, cycles;

  // Wire level: our driver when enabled, else the outside world
  assign pinB = (portBOe & portBOut) | (~portBOe & extB);
  assign pinC = (portCOe & portCOut) | (~portCOe & extC);
  assign pinD = (portDOe & portDOut) | (~portDOe & extD);

  hpio_host_model host (.sys_clk(sys_clk), .hostAddr(hostAddr),
    .hostWrData(hostWrData), .hostWrEn(hostWrEn), .hostRdEn(hostRdEn),
    .hostRdData(hostRdData));

  hpio_ports dut (.sys_clk(sys_clk), .rstn(rstn), .clkEn(clkEn),
    .hostAddr(hostAddr), .hostWrData(hostWrData), .hostWrEn(hostWrEn),
    .hostRdEn(hostRdEn), .hostRdData(hostRdData), .portBIn(pinB),
    .portBOut(portBOut), .portBOe(portBOe), .portBFastSlew(portBFastSlew),
    .portCIn(pinC), .portCOut(portCOut), .portCOe(portCOe),
    .portDIn(pinD), .portDOut(portDOut), .portDOe(portDOe),
    .portDFastSlew(portDFastSlew), .firstCellOut(firstCellOut),
    .secondCellOut(secondCellOut), .extSelect(extSelect),
    .bCellSel(bCellSel), .bSecondSel(bSecondSel), .cCellSel(cCellSel),
    .dCellSel(dCellSel), .bPtDefined(bPtDefined), .cPtDefined(cPtDefined),
    .dPtDefined(dPtDefined), .bEnTerm(bEnTerm), .cEnTerm(cEnTerm),
    .dEnTerm(dEnTerm), .bImcMode(bImcMode), .cImcMode(cImcMode),
    .bImcGate(bImcGate), .cImcGate(cImcGate), .ispEnable(ispEnable),
    .ispOutVal(ispOutVal), .ispOeVal(ispOeVal), .bArrayIn(bArrayIn),
    .cArrayIn(cArrayIn), .dArrayIn(dArrayIn));

  // 100 ns clock
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  // Hang guard, well above the expected 145 or so cycles
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 5000) begin
      num_errors++;
      final_report();
    end
  end

  task automatic check(input string nm, input logic [7:0] seen, exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic settle(input int n);
    repeat (n) @(negedge sys_clk);
  endtask

  task automatic final_report();
    if (num_errors == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // All twelve port registers and drivers idle after reset
  task automatic t_reset();
    for (int a = 0; a < 12; a++) begin
      host.rd(5'(a), v);
      check("reset reg", v, 8'h00);
    end
    check("oe reset", portBOe | portCOe | {5'h0, portDOe}, 8'h00);
  endtask

  // Read/write access, read-only data-in, narrow port D, unmapped hole
  task automatic t_regs();
    host.wr_rd(5'h01, 8'ha5, v);
    check("dout b", v, 8'ha5);
    host.wr(5'h00, 8'hff);
    host.rd(5'h00, v);
    check("din ro", v, 8'h00);
    host.wr(5'h09, 8'hff);
    host.rd(5'h09, v);
    check("dout d", v, 8'h07);
    host.wr(5'h0a, 8'hff);
    host.rd(5'h0a, v);
    check("dir d", v, 8'h07);
    host.rd(5'h10, v);
    check("unmapped", v, 8'h00);
    host.wr(5'h09, 8'h00);
    host.wr(5'h0a, 8'h00);
  endtask

  // Host mode: low nibble output, high nibble input, level readback
  task automatic t_host_mode();
    extB = 8'h3c;
    host.wr(5'h02, 8'h0f);
    settle(1);
    check("b oe dir", portBOe, 8'h0f);
    check("b out", portBOut & 8'h0f, 8'h05);
    settle(6);
    host.rd(5'h00, v);
    check("b level", v, 8'h35);
  endtask

  // Array-driven pins: source select, enable term OR direction
  task automatic t_array();
    bPtDefined = 8'h0f;
    bCellSel = 8'h0f;
    bSecondSel = 8'h0c;
    firstCellOut = 8'h01;
    secondCellOut = 8'hac;
    cCellSel = 8'hf0;
    dCellSel = 3'h7;
    extSelect = 3'h5;
    settle(2);
    check("b cells", portBOut & 8'h0f, 8'h0d);
    check("c cells", portCOut & 8'hf0, 8'ha0);
    check("c oe", portCOe & 8'hf0, 8'hf0);
    check("d sel", 8'(portDOut), 8'h05);
    check("d oe", 8'(portDOe), 8'h07);
    host.wr(5'h02, 8'h00);
    host.wr(5'h01, 8'h00);
    settle(1);
    check("b float", portBOe, 8'h00);
    check("b dout ign", portBOut & 8'h0f, 8'h0d);
    bEnTerm = 8'h06;
    settle(2);
    check("b en term", portBOe, 8'h06);
    bPtDefined = 8'h00;
    bCellSel = 8'h00;
    cCellSel = 8'h00;
    dCellSel = 3'h0;
    bEnTerm = 8'h00;
  endtask

  // Drive select: slew on B low and D, open drain on C
  task automatic t_drive();
    host.wr(5'h03, 8'hff);
    host.wr(5'h0b, 8'hff);
    settle(1);
    check("b slew", portBFastSlew, 8'h0f);
    check("d slew", 8'(portDFastSlew), 8'h07);
    host.rd(5'h0b, v);
    check("d drv", v, 8'h07);
    extC = 8'hff;
    host.wr(5'h07, 8'hff);
    host.wr(5'h06, 8'hff);
    host.wr(5'h05, 8'ha5);
    settle(1);
    check("c od out", portCOut, 8'h00);
    check("c od oe", portCOe, 8'h5a);
    settle(6);
    host.rd(5'h04, v);
    check("c level", v, 8'ha5);
  endtask

  // Input cells: pass, latch, register; port D goes straight in
  task automatic t_cells();
    extB = 8'h5a;
    extD = 3'h6;
    bImcGate = 2'b11;
    settle(6);
    check("imc pass", bArrayIn, 8'h5a);
    host.rd(5'h0c, v);
    check("imc read", v, 8'h5a);
    check("d direct", 8'(dArrayIn), 8'h06);
    check("c pass", cArrayIn, 8'ha5);
    host.rd(5'h0f, v);
    check("cell rd", v, 8'hac);
    bImcMode = 16'h5555;
    settle(2);
    bImcGate = 2'b00;
    extB = 8'ha5;
    settle(6);
    check("latch hold", bArrayIn, 8'h5a);
    bImcGate = 2'b01;
    settle(3);
    check("latch open", bArrayIn, 8'h55);
    bImcMode = 16'haaaa;
    bImcGate = 2'b00;
    settle(2);
    bImcGate = 2'b11;
    settle(3);
    extB = 8'h0f;
    settle(6);
    check("reg hold", bArrayIn, 8'ha5);
  endtask

  // Frozen clock enable drops a write; mid-run reset clears registers
  task automatic t_freeze_reset();
    clkEn = 1'b0;
    host.wr(5'h01, 8'h3c);
    clkEn = 1'b1;
    host.rd(5'h01, v);
    check("frozen wr", v, 8'h00);
    rstn = 1'b0;
    settle(2);
    rstn = 1'b1;
    host.rd(5'h06, v);
    check("rereset dir", v, 8'h00);
    check("rereset oe", portCOe, 8'h00);
  endtask

  // Programming function takes over the masked C pins
  task automatic t_isp();
    // Push-pull and input direction, so only the override drives C
    host.wr(5'h07, 8'h00);
    host.wr(5'h06, 8'h00);
    ispOutVal = 8'h0a;
    ispOeVal = 8'h0f;
    ispEnable = 1'b1;
    settle(2);
    check("isp out", portCOut & 8'h0f, 8'h0a);
    check("isp oe", portCOe & 8'h0f, 8'h0f);
  endtask

  // Main sequence; port C direction is all ones only from t_drive until the mid-run reset
  initial begin
    {rstn, ispEnable} = '0;
    clkEn = 1'b1;
    {firstCellOut, secondCellOut, bCellSel, bSecondSel, cCellSel} = '0;
    {bPtDefined, cPtDefined, bEnTerm, cEnTerm, ispOutVal, ispOeVal} = '0;
    {extB, extC, extD, extSelect, dCellSel, dPtDefined, dEnTerm} = '0;
    {bImcMode, cImcMode, bImcGate, cImcGate} = '0;
    settle(12);
    rstn = 1'b1;
    t_reset();
    t_regs();
    t_host_mode();
    t_array();
    t_drive();
    t_cells();
    t_freeze_reset();
    t_isp();
    final_report();
  end
endmodule
